// *** hdl/acc_pkg.sv ***
/*
 Constants for the converter control block: register offsets, field positions,
 reset values and timing counts. Assumes a 125 MHz APB clock.
*/
package acc_pkg;
	localparam int ACC_CLK_MHZ = 125;
	localparam logic [7:0] ACC_IDX_CTRL = 8'h1F;
	localparam logic [7:0] ACC_IDX_PINCFG = 8'h9F;
	localparam logic [7:0] ACC_IDX_RES_HI = 8'h1E;
	localparam logic [7:0] ACC_IDX_RES_LO = 8'h9E;
	localparam logic [7:0] ACC_IDX_STATUS = 8'h20;
	localparam logic [7:0] ACC_IDX_SAMPLE = 8'h21;
	localparam int ACC_BIT_POWER = 0;
	localparam int ACC_BIT_GO = 2;
	localparam int ACC_CHAN_LSB = 3;
	localparam int ACC_CLKSEL_LSB = 6;
	localparam logic [7:0] ACC_CTRL_RESET = 8'h00;
	localparam logic [7:0] ACC_PINCFG_RESET = 8'h00;
	localparam logic [7:0] ACC_CTRL_WMASK = 8'hFD;
	localparam int ACC_DIV_CODE0 = 2;
	localparam int ACC_DIV_CODE1 = 8;
	localparam int ACC_DIV_CODE2 = 32;
	localparam int ACC_RC_PERIOD_NS = 4000;
	localparam int ACC_RC_CYCLES = (ACC_RC_PERIOD_NS * ACC_CLK_MHZ) / 1000;
	localparam int ACC_CONV_STEPS = 12;
	localparam int ACC_RES_BITS = 10;
	localparam int ACC_CHANNELS = 8;
	localparam int ACC_CHANNELS_SMALL = 5;
	localparam logic [1:0] ACC_CLKSEL_RC = 2'h3;
	typedef enum logic [1:0]
	{
		ACC_IDLE = 2'b00,
		ACC_SETTLE = 2'b01,
		ACC_CONVERT = 2'b10,
		ACC_FINISH = 2'b11
	} acc_state_e;
endpackage

// *** hdl/acc_sar_reg.sv ***
/*
 Successive-approximation register: holds the trial word and decides one bit
 per step from the top down. Assumes the comparator answer is valid at each step.
*/
`timescale 1ns/10ps
module acc_sar_reg
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic clear,
	input wire logic load,
	input wire logic step,
	input wire logic [3:0] bit_index,
	input wire logic comp_high,
	output logic [9:0] trial
);
	import acc_pkg::*;

	// =========================================
	// Trial word
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			trial <= 10'h000;
		else if (clear)
			trial <= 10'h000;
		else if (load)
			trial <= 10'h200;
		else if (step)
		begin
			trial[bit_index] <= comp_high;
			if (bit_index != 4'h0)
				trial[bit_index - 4'h1] <= 1'b1;
		end
	end
endmodule

// *** hdl/acc_top.sv ***
/*
 APB-reached control logic of a 10-bit successive-approximation converter:
 control, pin configuration and result registers plus the conversion sequencer.
 Assumes an external comparator that reports whether the selected analog input
 lies above the current trial level.
*/
// Implementation choice: the APB slave port.
`timescale 1ns/10ps

// How it works
// - The channel field reaches eight inputs, five of them on the small package.
// - Each conversion yields a 10-bit unsigned result.
// - The sequencer decides one result bit per bit period from the top down.
// - High and low references come from the rails or the two reference pins.
// - In sleep only the RC clock choice keeps converting; other choices halt.
// - Control bits 5 to 3 select channel n for code n.
// - Writing one to the go bit while powered starts a conversion.
// - Hardware clears the go bit at completion unless a control write setting go lands in that cycle, which leaves it reading one while idle.
// - Control, pin configuration and the two result bytes are software registers.
// - The pin configuration register marks pins analog or digital and picks pin or rail for each of the two references.
// - Clock select codes 00, 01, 10 give 2, 8, 32 oscillator periods, 11 the RC clock.
// - On completion the result pair loads and the done flag sets; go clears unless a control write setting go lands in that cycle.
// - A conversion takes twelve bit periods from start to result.
module acc_top
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic small_package,
	input wire logic sleep_mode,
	input wire logic comp_high,
	output logic [2:0] selected_channel,
	output logic [9:0] trial_level,
	output logic sample_hold,
	output logic [3:0] pin_config,
	output logic high_ref_from_pin,
	output logic low_ref_from_pin,
	output logic converter_active,
	output logic conversion_done_flag
);
	import acc_pkg::*;

	logic [7:0] converter_control_reg_r;
	logic [7:0] pin_config_reg_r;
	logic [9:0] result_r;
	logic conversion_done_flag_r;
	acc_state_e state_r;
	logic [8:0] div_cnt_r;
	logic [3:0] step_cnt_r;
	logic [9:0] trial;
	logic tick;
	logic wr_en;
	logic rd_en;
	logic [7:0] word_idx;
	logic mapped;
	logic go_write;
	logic abort;
	logic halted;
	logic sar_load;
	logic sar_step;
	logic finish;
	logic [8:0] div_limit;
	logic [31:0] rd_val;

	// =========================================
	// Helpers
	function automatic logic [8:0] acc_div_limit(input logic [1:0] code);
		logic [8:0] lim;
		lim = 9'(ACC_RC_CYCLES - 1);
		unique case (code)
			2'h0: lim = 9'(ACC_DIV_CODE0 - 1);
			2'h1: lim = 9'(ACC_DIV_CODE1 - 1);
			2'h2: lim = 9'(ACC_DIV_CODE2 - 1);
			2'h3: lim = 9'(ACC_RC_CYCLES - 1);
		endcase
		return lim;
	endfunction

	function automatic logic acc_is_mapped(input logic [7:0] idx);
		return (idx == ACC_IDX_CTRL) || (idx == ACC_IDX_PINCFG) || (idx == ACC_IDX_RES_HI) ||
			(idx == ACC_IDX_RES_LO) || (idx == ACC_IDX_STATUS) || (idx == ACC_IDX_SAMPLE);
	endfunction

	// =========================================
	// APB decode
	assign word_idx = paddr[9:2];
	assign mapped = acc_is_mapped(word_idx) && (paddr[31:10] == 22'h0) && (paddr[1:0] == 2'h0);
	assign pready = 1'b1;
	assign pslverr = psel && penable && !mapped;
	assign wr_en = psel && penable && pwrite && mapped;
	assign rd_en = psel && penable && !pwrite && mapped;
	assign go_write = wr_en && (word_idx == ACC_IDX_CTRL) && pwdata[ACC_BIT_GO];
	assign abort = wr_en && (word_idx == ACC_IDX_CTRL) && !pwdata[ACC_BIT_GO];

	// =========================================
	// Control register
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			converter_control_reg_r <= ACC_CTRL_RESET;
		else if (wr_en && (word_idx == ACC_IDX_CTRL))
		begin
			converter_control_reg_r <= pwdata[7:0] & ACC_CTRL_WMASK;
			if (!pwdata[ACC_BIT_POWER] || !converter_control_reg_r[ACC_BIT_POWER])
				converter_control_reg_r[ACC_BIT_GO] <= 1'b0;
		end
		else if (finish || !converter_control_reg_r[ACC_BIT_POWER])
			converter_control_reg_r[ACC_BIT_GO] <= 1'b0;
	end

	// =========================================
	// Pin configuration register
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			pin_config_reg_r <= ACC_PINCFG_RESET;
		else if (wr_en && (word_idx == ACC_IDX_PINCFG))
			pin_config_reg_r <= pwdata[7:0];
	end

	assign pin_config = pin_config_reg_r[3:0];
	assign high_ref_from_pin = pin_config_reg_r[4];
	assign low_ref_from_pin = pin_config_reg_r[5];
	assign selected_channel = converter_control_reg_r[ACC_CHAN_LSB +: 3];

	// =========================================
	// Bit period generator
	assign div_limit = acc_div_limit(converter_control_reg_r[ACC_CLKSEL_LSB +: 2]);
	assign halted = sleep_mode && (converter_control_reg_r[ACC_CLKSEL_LSB +: 2] != ACC_CLKSEL_RC);
	assign tick = (div_cnt_r == div_limit) && !halted;

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			div_cnt_r <= 9'h000;
		else if (state_r == ACC_IDLE)
			div_cnt_r <= 9'h000;
		else if (halted)
			div_cnt_r <= div_cnt_r;
		else if (tick)
			div_cnt_r <= 9'h000;
		else
			div_cnt_r <= div_cnt_r + 9'h001;
	end

	// =========================================
	// Conversion sequencer
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			state_r <= ACC_IDLE;
			step_cnt_r <= 4'h0;
		end
		else if (abort || !converter_control_reg_r[ACC_BIT_POWER])
		begin
			state_r <= ACC_IDLE;
			step_cnt_r <= 4'h0;
		end
		else
		begin
			unique case (state_r)
				ACC_IDLE:
				begin
					if (go_write && converter_control_reg_r[ACC_BIT_POWER])
						state_r <= ACC_SETTLE;
					step_cnt_r <= 4'h0;
				end
				ACC_SETTLE:
				begin
					if (tick)
					begin
						state_r <= ACC_CONVERT;
						step_cnt_r <= 4'(ACC_RES_BITS - 1);
					end
				end
				ACC_CONVERT:
				begin
					if (tick)
					begin
						if (step_cnt_r == 4'h0)
							state_r <= ACC_FINISH;
						else
							step_cnt_r <= step_cnt_r - 4'h1;
					end
				end
				ACC_FINISH:
				begin
					if (tick)
						state_r <= ACC_IDLE;
				end
			endcase
		end
	end

	assign sar_load = (state_r == ACC_SETTLE) && tick && !abort;
	assign sar_step = (state_r == ACC_CONVERT) && tick && !abort;
	assign finish = (state_r == ACC_FINISH) && tick && !abort && converter_control_reg_r[ACC_BIT_POWER];
	assign sample_hold = (state_r != ACC_IDLE);
	assign converter_active = converter_control_reg_r[ACC_BIT_POWER];

	acc_sar_reg u_sar
	(
		.pclk(pclk),
		.presetn(presetn),
		.clear(state_r == ACC_IDLE),
		.load(sar_load),
		.step(sar_step),
		.bit_index(step_cnt_r),
		.comp_high(comp_high),
		.trial(trial)
	);

	assign trial_level = trial;

	// =========================================
	// Result pair and done flag
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			result_r <= 10'h000;
		else if (finish)
			result_r <= trial;
		else if (wr_en && (word_idx == ACC_IDX_RES_HI))
			result_r[9:8] <= pwdata[1:0];
		else if (wr_en && (word_idx == ACC_IDX_RES_LO))
			result_r[7:0] <= pwdata[7:0];
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			conversion_done_flag_r <= 1'b0;
		else if (finish)
			conversion_done_flag_r <= 1'b1;
		else if (wr_en && (word_idx == ACC_IDX_STATUS) && pwdata[0])
			conversion_done_flag_r <= 1'b0;
	end

	assign conversion_done_flag = conversion_done_flag_r;

	// =========================================
	// Read data
	always_comb
	begin
		rd_val = 32'h0000_0000;
		unique case (word_idx)
			ACC_IDX_CTRL: rd_val = {24'h0, converter_control_reg_r};
			ACC_IDX_PINCFG: rd_val = {24'h0, pin_config_reg_r};
			ACC_IDX_RES_HI: rd_val = {30'h0, result_r[9:8]};
			ACC_IDX_RES_LO: rd_val = {24'h0, result_r[7:0]};
			ACC_IDX_STATUS: rd_val = {29'h0, small_package, halted, conversion_done_flag_r};
			ACC_IDX_SAMPLE: rd_val = {20'h0, state_r, trial};
			default: rd_val = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			prdata <= 32'h0000_0000;
		else if (psel && !penable && !pwrite)
			prdata <= mapped ? rd_val : 32'h0000_0000;
		else if (!rd_en)
			prdata <= prdata;
	end
endmodule

// *** verif/acc_analog.sv ***
/*
 Analog inputs and comparator model.
 Assumes each channel holds a fixed level.
*/
`timescale 1ns/10ps
// ==========
// Analog model
module acc_analog
(
	input wire logic [2:0] selected_channel,
	input wire logic [9:0] trial_level,
	output logic comp_high
);
	always_comb comp_high = {selected_channel, ~selected_channel, 4'h9} >= trial_level;
endmodule

// *** verif/acc_props.sv ***
/*
 Checker for the converter control block ports.
 Assumes it is bound into acc_top.
*/
`timescale 1ns/10ps
// ==========
// Checker
module acc_props
import acc_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pslverr,
	input wire logic [2:0] selected_channel,
	input wire logic sample_hold,
	input wire logic [3:0] pin_config,
	input wire logic high_ref_from_pin,
	input wire logic low_ref_from_pin,
	input wire logic converter_active,
	input wire logic conversion_done_flag
);
	default clocking @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	wire logic ac = paddr == {22'h0, ACC_IDX_CTRL, 2'h0};
	wire logic wc = psel & penable & pwrite & ac;
	wire logic wp = psel & penable & pwrite & (paddr == {22'h0, ACC_IDX_PINCFG, 2'h0});
	logic [4:0] run_cnt;
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			run_cnt <= 5'h00;
		else if (!sample_hold)
			run_cnt <= 5'h00;
		else if (run_cnt != 5'h1F)
			run_cnt <= run_cnt + 5'h01;
	end
	property p_err;
		psel & penable & (paddr[1:0] != 2'h0) |-> pslverr;
	endproperty
	a_err: assert property (p_err) else $error("misaligned access not refused");
	property p_chan;
		wc |=> selected_channel == $past(pwdata[5:3]);
	endproperty
	a_chan: assert property (p_chan) else $error("channel field not applied");
	property p_pwr;
		wc |=> converter_active == $past(pwdata[0]);
	endproperty
	a_pwr: assert property (p_pwr) else $error("power bit not applied");
	property p_pin;
		wp |=> {low_ref_from_pin, high_ref_from_pin, pin_config} == $past(pwdata[5:0]);
	endproperty
	a_pin: assert property (p_pin) else $error("pin setup not applied");
	property p_bit1;
		psel & !penable & !pwrite & ac |=> prdata[1] == 1'b0;
	endproperty
	a_bit1: assert property (p_bit1) else $error("control bit 1 reads one");
	property p_off;
		wc & !converter_active & pwdata[2] |=> !sample_hold;
	endproperty
	a_off: assert property (p_off) else $error("start while unpowered");
	property p_start;
		wc & converter_active & pwdata[0] & pwdata[2] & !sample_hold |-> ##[1:3] sample_hold;
	endproperty
	a_start: assert property (p_start) else $error("start did not begin");
	property p_len;
		$fell(sample_hold) & !$past(wc) & !$past(wc, 2) |-> $past(run_cnt) >= 5'h17;
	endproperty
	a_len: assert property (p_len) else $error("conversion too short");
	property p_done;
		$rose(conversion_done_flag) |-> $past(sample_hold);
	endproperty
	a_done: assert property (p_done) else $error("done flag without conversion");
	property p_idle;
		!converter_active [*2] |-> !sample_hold;
	endproperty
	a_idle: assert property (p_idle) else $error("converting while off");
endmodule
bind acc_top acc_props acc_props_i (.*);

// *** verif/tb.sv ***
/*
 Testbench for acc_top with the analog model.
 Assumes a zero wait state APB slave.
*/
`timescale 1ns/10ps
// ==========
// Bench
module tb;
	import acc_pkg::*;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, er;
	logic [31:0] paddr = 0, pwdata = 0, prdata, rd;
	logic pready, pslverr, small_package = 0, sleep_mode = 0, comp_high, sample_hold;
	logic high_ref_from_pin, low_ref_from_pin, converter_active, conversion_done_flag;
	logic [2:0] selected_channel;
	logic [9:0] trial_level;
	logic [3:0] pin_config;
	int n_mismatch = 0, check_count = 0, cyc = 0;
	localparam logic [31:0] A_CTRL = {22'h0, ACC_IDX_CTRL, 2'h0};
	localparam logic [31:0] A_PIN = {22'h0, ACC_IDX_PINCFG, 2'h0};
	localparam logic [31:0] A_HI = {22'h0, ACC_IDX_RES_HI, 2'h0};
	localparam logic [31:0] A_LO = {22'h0, ACC_IDX_RES_LO, 2'h0};
	localparam logic [31:0] A_ST = {22'h0, ACC_IDX_STATUS, 2'h0};
	always #4 pclk = ~pclk;
	acc_top acc_top_i (.*);
	acc_analog acc_analog_i (.*);
	always @(posedge pclk)
	begin
		cyc <= cyc + 1;
		if (cyc == 20000)
		begin
			n_mismatch++;
			summarize();
		end
	end
	task summarize;
		$display("checks %0d mismatches %0d", check_count, n_mismatch);
		if (n_mismatch == 0 && check_count > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task check(input logic [31:0] s, input logic [31:0] e);
		check_count++;
		if (s !== e)
		begin
			n_mismatch++;
			$display("[ERR] %0t seen %h exp %h", $time, s, e);
		end
	endtask
	task apb(input logic w, input logic [31:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1;
		penable <= 0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 0;
		penable <= 0;
	endtask
	task t_regs;
		apb(0, A_CTRL, 0);
		check(rd, ACC_CTRL_RESET);
		apb(0, A_PIN, 0);
		check(rd, ACC_PINCFG_RESET);
		apb(1, A_CTRL, 32'hFE);
		apb(0, A_CTRL, 0);
		check(rd, 32'hF8);
		apb(1, A_PIN, 32'h25);
		@(posedge pclk);
		check({low_ref_from_pin, high_ref_from_pin, pin_config}, 6'h25);
		apb(0, 32'h3FC, 0);
		check(er, 1);
		check(rd, 0);
		apb(0, A_CTRL + 32'h1, 0);
		check(er, 1);
		check(rd, 0);
		$display("regs done");
	endtask
	task conv(input logic [1:0] k, input logic [2:0] c);
		int d;
		int n;
		logic [9:0] lv;
		d = k == 0 ? ACC_DIV_CODE0 : k == 1 ? ACC_DIV_CODE1 : k == 2 ? ACC_DIV_CODE2 : ACC_RC_CYCLES;
		lv = {c, ~c, 4'h9};
		apb(1, A_CTRL, {24'h0, k, c, 3'h1});
		apb(1, A_CTRL, {24'h0, k, c, 3'h5});
		n = 0;
		while (sample_hold !== 1'b1 && n < 4)
		begin
			@(posedge pclk);
			n++;
		end
		n = 0;
		while (sample_hold === 1'b1)
		begin
			@(posedge pclk);
			n++;
		end
		check({n >= 12 * d - 2, n <= 12 * d + 2}, 2'h3);
		check(conversion_done_flag, 1);
		check(selected_channel, c);
		apb(0, A_CTRL, 0);
		check(rd, {24'h0, k, c, 3'h1});
		apb(0, A_HI, 0);
		check(rd, {30'h0, lv[9:8]});
		apb(0, A_LO, 0);
		check(rd, {24'h0, lv[7:0]});
		apb(1, A_ST, 1);
		$display("conversion done");
	endtask
	task t_abort;
		apb(1, A_CTRL, 32'h4D);
		repeat (20) @(posedge pclk);
		apb(1, A_CTRL, 32'h49);
		@(posedge pclk);
		check(sample_hold, 0);
		check(conversion_done_flag, 0);
		apb(0, A_LO, 0);
		check(rd, 32'h89);
		$display("abort done");
	endtask
	task t_sleep;
		sleep_mode <= 1;
		apb(1, A_CTRL, 32'h05);
		repeat (100) @(posedge pclk);
		apb(0, A_CTRL, 0);
		check(rd[2], 1);
		apb(0, A_ST, 0);
		check(rd[1], 1);
		sleep_mode <= 0;
		repeat (100) @(posedge pclk);
		apb(0, A_CTRL, 0);
		check(rd[2], 0);
		apb(1, A_ST, 1);
		sleep_mode <= 1;
		conv(2'h3, 3'h6);
		sleep_mode <= 0;
		$display("sleep done");
	endtask
	initial
	begin
		repeat (4) @(posedge pclk);
		presetn <= 1;
		t_regs();
		for (int k = 0; k < 3; k++)
			conv(k[1:0], 3'(k * 3));
		small_package <= 1;
		conv(2'h0, 3'h7);
		apb(0, A_ST, 0);
		check(rd[2], 1);
		t_abort();
		t_sleep();
		summarize();
	end
endmodule
